// ### hdl/adc_ctrl_pkg.sv
// package for the converter control-byte decoder and power-mode sequencer
// assumes one 200 mhz system clock; serial pins are asynchronous to it
package adc_ctrl_pkg;

   // -------------------------------------------------------------------
   // control byte layout
   // -------------------------------------------------------------------
   localparam int CB_MARKER_POS   = 7;
   localparam int CB_CHAN_HI_POS  = 6;
   localparam int CB_CHAN_LO_POS  = 4;
   localparam int CB_POLARITY_POS = 3;
   localparam int CB_INPUT_POS    = 2;
   localparam int CB_PWR_HI_POS   = 1;
   localparam int CB_PWR_LO_POS   = 0;
   localparam int CB_BITS         = 8;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int WAKE_TIME_NS    = 2000;
   // least time, rounded up to whole cycles
   localparam int WAKE_CYCLES     = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_CNT_W      = 9;
   localparam int CONV_EDGES      = 12;
   localparam int CONV_CNT_W      = 4;
   localparam int BUF_DEPTH       = 2;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [1:0] PWR_RESET    = 2'h3;
   localparam logic [7:0] CTRL_RESET   = 8'h00;

   // power mode codes
   typedef enum logic [1:0]
   {
      full_sleep_mode  = 2'h0,
      quick_sleep_mode = 2'h1,
      low_power_mode   = 2'h2,
      normal_mode      = 2'h3
   } power_mode_t;

   // decoded control byte
   typedef struct packed
   {
      logic [2:0]  channel_choice;
      logic        polarity_choice;
      logic        input_config_choice;
      power_mode_t power_mode;
   } ctrl_fields_t;

   // circuit power states
   typedef struct packed
   {
      logic comparator_on;
      logic comparator_full;
      logic reference_on;
   } power_state_t;

endpackage

// ### hdl/ctrl_buffer.sv
// two-entry valid/ready buffer carrying decoded control fields
// assumes both sides on the same clock
`timescale 1ns/1ps
module ctrl_buffer
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire ctrl_fields_t in_data,
   // draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output ctrl_fields_t      out_data
);

   // -------------------------------------------------------------------
   // storage
   // -------------------------------------------------------------------
   ctrl_fields_t mem_q [BUF_DEPTH];
   ctrl_fields_t mem_d [BUF_DEPTH];
   logic         wr_q, wr_d, rd_q, rd_d;
   logic [1:0]   cnt_q, cnt_d;

   // next-state: push and pop in the same cycle are both allowed
   always_comb
   begin
      logic push;
      logic pop;
      push  = in_valid && (cnt_q != 2'd2);
      pop   = out_ready && (cnt_q != 2'd0);
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data;
         wr_d        = ~wr_q;
      end
      if (pop)
         rd_d = ~rd_q;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   // register stage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'd0;
      end
      else
      begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   assign in_ready  = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data  = mem_q[rd_q];

endmodule

// ### hdl/adc_ctrl.sv
// control-byte decoder and software power-mode sequencer of a serial converter
// assumes spi mode 0 host; sclk, cs_n and din are asynchronous pins
//
// Overview of operation
// - with chip select low the first one shifted in is taken as bit 7 of the byte.
// - bits 6 to 4 choose the input channels for the conversion.
// - bit 3 at one gives unipolar coding and at zero bipolar coding.
// - bit 2 at one measures one input against the shared negative, at zero a pair.
// - after a conversion the byte's power mode holds until the next byte arrives; the code applies the last popped head's mode, an older byte's in a stall.
// - all circuits run during conversion; between, each code sets comparator and reference.
// - after reset or leaving full sleep the device is full power and ready 2 us later.
// - quick sleep and low power accept a new conversion at once with no wake wait.
// - power codes are 00 full sleep, 01 quick sleep, 10 low power, 11 normal.
// - zeros before the marker are ignored; conversion starts on the falling edge after bit 8.
// - results are straight binary when unipolar, two's complement when bipolar, msb first.
// - any software sleep returns to full power on the marker of a new byte.
`timescale 1ns/1ps
module adc_ctrl
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // serial pins
   input  wire logic         sclk,
   input  wire logic         cs_n,
   input  wire logic         din,
   input  wire logic         hw_shutdown_n,
   // decoded settings
   output logic [2:0]        channel_choice,
   output logic              polarity_choice,
   output logic              input_config_choice,
   output logic              twos_complement,
   output power_mode_t       power_mode,
   // power and conversion state
   output power_state_t      power_state,
   output logic              converting,
   output logic              ready_to_convert,
   output logic              conv_start,
   output logic              sample_strobe,
   // strobe from converter core
   input  wire logic         sar_ready
);

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   logic [3:0] meta_q, sync_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q <= 4'h5;
         sync_q <= 4'h5;
      end
      else
      begin
         meta_q <= {sclk, cs_n, din, hw_shutdown_n};
         sync_q <= meta_q;
      end
   end

   logic sclk_s, cs_n_s, din_s, hw_shutdown_n_n_s;
   assign {sclk_s, cs_n_s, din_s, hw_shutdown_n_n_s} = sync_q;

   // -------------------------------------------------------------------
   // shifter and power sequencer
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {s_idle, s_shift, s_wait_fall, s_conv} seq_t;

   seq_t         seq_q, seq_d;
   logic         sclk_prev_q, sclk_prev_d;
   logic [7:0]   sh_q, sh_d;
   logic [2:0]   bitcnt_q, bitcnt_d;
   logic [CONV_CNT_W-1:0] conv_q, conv_d;
   logic [WAKE_CNT_W-1:0] wake_q, wake_d;
   ctrl_fields_t active_q, active_d;
   power_mode_t  pmode_q, pmode_d;
   logic         conv_start_q, conv_start_d;
   logic         strobe_q, strobe_d;
   logic         buf_valid, buf_ready, out_valid;
   ctrl_fields_t buf_data, out_data;
   logic         rise, fall;

   // field decode used for the buffer push
   function automatic ctrl_fields_t decode(input logic [7:0] b);
      ctrl_fields_t f;
      f.channel_choice      = b[CB_CHAN_HI_POS:CB_CHAN_LO_POS];
      f.polarity_choice     = b[CB_POLARITY_POS];
      f.input_config_choice = b[CB_INPUT_POS];
      f.power_mode          = power_mode_t'(b[CB_PWR_HI_POS:CB_PWR_LO_POS]);
      return f;
   endfunction

   assign rise = sclk_s && !sclk_prev_q;
   assign fall = !sclk_s && sclk_prev_q;

   // next-state of the frame sequencer
   always_comb
   begin
      seq_d        = seq_q;
      sclk_prev_d  = sclk_s;
      sh_d         = sh_q;
      bitcnt_d     = bitcnt_q;
      conv_d       = conv_q;
      wake_d       = (wake_q != '0) ? wake_q - 1'b1 : wake_q;
      pmode_d      = pmode_q;
      conv_start_d = 1'b0;
      strobe_d     = strobe_q;
      buf_valid    = 1'b0;
      buf_data     = decode(sh_q);
      if (!hw_shutdown_n_n_s)
      begin
         // hardware shutdown stops any conversion at once
         seq_d    = s_idle;
         strobe_d = 1'b0;
         wake_d   = WAKE_CNT_W'(WAKE_CYCLES);
         pmode_d  = normal_mode;
      end
      else
      begin
         unique case (seq_q)
            s_idle:
               if (!cs_n_s && rise && din_s)
               begin
                  sh_d     = 8'h01;
                  bitcnt_d = 3'd1;
                  seq_d    = s_shift;
                  if (pmode_q == full_sleep_mode)
                     wake_d = WAKE_CNT_W'(WAKE_CYCLES);
                  pmode_d  = normal_mode;
               end
            s_shift:
               if (cs_n_s)
                  seq_d = s_idle;
               else if (rise)
               begin
                  sh_d     = {sh_q[6:0], din_s};
                  bitcnt_d = bitcnt_q + 3'd1;
                  if (bitcnt_q == 3'd7)
                     seq_d = s_wait_fall;
               end
            s_wait_fall:
               if (fall && buf_ready)
               begin
                  buf_valid    = 1'b1;
                  conv_start_d = 1'b1;
                  strobe_d     = 1'b1;
                  conv_d       = '0;
                  seq_d        = s_conv;
               end
            s_conv:
               if (fall)
               begin
                  strobe_d = 1'b0;
                  conv_d   = conv_q + 1'b1;
                  if (conv_q == CONV_CNT_W'(CONV_EDGES - 1))
                  begin
                     seq_d   = s_idle;
                     pmode_d = active_q.power_mode;
                  end
               end
            default:
               seq_d = s_idle;
         endcase
      end
      if (cs_n_s)
         strobe_d = 1'b0;
   end

   // applied settings change only when the core pops the head; a stalled core keeps the old ones
   assign active_d = (out_valid && sar_ready) ? out_data : active_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         seq_q        <= s_idle;
         sclk_prev_q  <= 1'b0;
         sh_q         <= CTRL_RESET;
         bitcnt_q     <= 3'd0;
         conv_q       <= '0;
         wake_q       <= WAKE_CNT_W'(WAKE_CYCLES);
         pmode_q      <= power_mode_t'(PWR_RESET);
         conv_start_q <= 1'b0;
         strobe_q     <= 1'b0;
         active_q     <= '0;
      end
      else
      begin
         seq_q        <= seq_d;
         sclk_prev_q  <= sclk_prev_d;
         sh_q         <= sh_d;
         bitcnt_q     <= bitcnt_d;
         conv_q       <= conv_d;
         wake_q       <= wake_d;
         pmode_q      <= pmode_d;
         conv_start_q <= conv_start_d;
         strobe_q     <= strobe_d;
         active_q     <= active_d;
      end
   end

   // -------------------------------------------------------------------
   // control buffer: up to two decoded bytes wait here for a busy core; while it is full the sequencer holds the next byte and ignores further frames
   // -------------------------------------------------------------------
   ctrl_buffer u_buf
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (buf_valid),
      .in_ready  (buf_ready),
      .in_data   (buf_data),
      .out_valid (out_valid),
      .out_ready (sar_ready),
      .out_data  (out_data)
   );

   // -------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------
   power_state_t pstate_d;
   always_comb
   begin
      // during conversion everything runs fully
      if (seq_q == s_conv || seq_q == s_wait_fall)
         pstate_d = '{1'b1, 1'b1, 1'b1};
      else
         unique case (pmode_q)
            full_sleep_mode:  pstate_d = '{1'b0, 1'b0, 1'b0};
            quick_sleep_mode: pstate_d = '{1'b1, 1'b0, 1'b1};
            low_power_mode:   pstate_d = '{1'b1, 1'b0, 1'b1};
            normal_mode:      pstate_d = '{1'b1, 1'b1, 1'b1};
         endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         channel_choice      <= '0;
         polarity_choice     <= 1'b0;
         input_config_choice <= 1'b0;
         twos_complement     <= 1'b0;
         power_mode          <= power_mode_t'(PWR_RESET);
         power_state         <= '{1'b1, 1'b1, 1'b1};
         converting          <= 1'b0;
         ready_to_convert    <= 1'b0;
         conv_start          <= 1'b0;
         sample_strobe       <= 1'b0;
      end
      else
      begin
         channel_choice      <= active_q.channel_choice;
         polarity_choice     <= active_q.polarity_choice;
         input_config_choice <= active_q.input_config_choice;
         twos_complement     <= !active_q.polarity_choice;
         power_mode          <= pmode_q;
         power_state         <= pstate_d;
         converting          <= (seq_q == s_conv);
         ready_to_convert    <= (wake_q == '0) && hw_shutdown_n_n_s;
         conv_start          <= conv_start_q;
         sample_strobe       <= strobe_q;
      end
   end

endmodule

// ### bench/adc_ctrl_properties.sv
// assertion checker for the control-byte decoder, bound into adc_ctrl
// assumes one clock domain and the package power codes
`timescale 1ns/1ps
module adc_ctrl_checker
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic         clk,
   input wire logic         arst_n,
   // watched pins and outputs
   input wire logic         hw_shutdown_n,
   input wire logic         polarity_choice,
   input wire logic         twos_complement,
   input wire power_mode_t  power_mode,
   input wire power_state_t power_state,
   input wire logic         converting,
   input wire logic         ready_to_convert,
   input wire logic         conv_start,
   input wire logic         sample_strobe
);
   // -------------------------------------------------------------------
   // helper logic
   // -------------------------------------------------------------------
   logic [2:0] mode_state;
   logic [9:0] wake_cnt_d;
   logic [9:0] wake_cnt_q;

   // expected circuit state per mode; wait counter saturates in long waits for ready
   always_comb
   begin
      mode_state = 3'h5;
      if (power_mode == full_sleep_mode)
         mode_state = 3'h0;
      if (power_mode == normal_mode)
         mode_state = 3'h7;
      wake_cnt_d = wake_cnt_q;
      if (ready_to_convert || !hw_shutdown_n)
         wake_cnt_d = 10'h000;
      else if (wake_cnt_q != 10'h3ff)
         wake_cnt_d = wake_cnt_q + 10'h001;
   end

   // counter register only
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         wake_cnt_q <= 10'h000;
      else
         wake_cnt_q <= wake_cnt_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start pulse longer than one cycle");
   a_strobe_start: assert property (conv_start |-> sample_strobe)
      else $error("strobe missing at start");
   a_start_converts: assert property (conv_start |-> ##[0:2] converting)
      else $error("start without conversion");
   a_coding_follows: assert property ($changed(polarity_choice) |-> twos_complement != polarity_choice)
      else $error("coding does not follow polarity");
   a_conv_full_power: assert property (converting |-> power_state == 3'h7)
      else $error("circuits not fully on while converting");
   a_mode_state: assert property (hw_shutdown_n && $past(hw_shutdown_n, 6) && $stable(power_mode)
      && !converting |-> power_state == mode_state)
      else $error("circuit state does not match mode");
   a_mode_hold: assert property ($changed(power_mode) |-> power_mode == normal_mode
      || $past(converting) || $past(converting, 2))
      else $error("mode changed outside conversion end");
   a_wake_time: assert property ($rose(ready_to_convert) |-> wake_cnt_q >= WAKE_CYCLES - 1)
      else $error("ready before wake time");
   a_ready_drops: assert property ($fell(hw_shutdown_n) |-> ##[1:4] !ready_to_convert)
      else $error("ready held in shutdown");
   a_ready_kept: assert property (ready_to_convert && hw_shutdown_n
      && power_mode != full_sleep_mode |=> ready_to_convert)
      else $error("wake wait added outside full sleep");
endmodule

bind adc_ctrl adc_ctrl_checker chk (.clk(clk), .arst_n(arst_n), .hw_shutdown_n(hw_shutdown_n),
   .polarity_choice(polarity_choice), .twos_complement(twos_complement),
   .power_mode(power_mode), .power_state(power_state), .converting(converting),
   .ready_to_convert(ready_to_convert), .conv_start(conv_start),
   .sample_strobe(sample_strobe));

// ### bench/spi_host.sv
// serial host model: one control byte per frame, spi mode 0
// assumes the bench clock for pacing; sclk rests low between frames
`timescale 1ns/1ps
module spi_host
(
   // pacing clock
   input  wire logic clk,
   // serial pins
   output logic      sclk,
   output logic      cs_n,
   output logic      din
);
   // idle pins
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b1;
   end

   // one sclk period of 25 cycles, 125 ns; data set while sclk low
   task automatic pulse(input logic b);
      din <= b;
      repeat (13) @(negedge clk);
      sclk <= 1'b1;
      repeat (12) @(negedge clk);
      sclk <= 1'b0;
   endtask

   // short nbits aborts the byte; slow stretches the frame end
   task automatic frame(input logic [7:0] b, input int zeros, input int nbits, input int slow);
      @(negedge clk);
      cs_n <= 1'b0;
      repeat (zeros) pulse(1'b0);
      for (int i = 7; i > 7 - nbits; i--)
         pulse(b[i]);
      if (nbits == 8)
         repeat (16) pulse(1'b0);
      repeat (slow) @(negedge clk);
      cs_n <= 1'b1;
      din  <= ~din; // released line shows no stale level
   endtask
endmodule

// ### bench/adc_ctrl_tb.sv
// self-checking bench for adc_ctrl with the serial host model
// assumes the host paces sclk from the bench clock
`timescale 1ns/1ps
module adc_ctrl_tb;
   import adc_ctrl_pkg::*;
   logic         clk;
   logic         arst_n;
   logic         hw_shutdown_n;
   logic         sar_ready;
   logic         sclk, cs_n, din;
   logic [2:0]   channel_choice;
   logic         polarity_choice, input_config_choice, twos_complement;
   power_mode_t  power_mode;
   power_state_t power_state;
   logic         converting, ready_to_convert, conv_start, sample_strobe;
   int           n_fail = 0;
   int           checked = 0;
   int           starts = 0;
   int           n0;
   logic [7:0]   bytes [4] = '{8'h9D, 8'hD2, 8'hAB, 8'hE4};

   adc_ctrl dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .hw_shutdown_n(hw_shutdown_n), .channel_choice(channel_choice),
      .polarity_choice(polarity_choice), .input_config_choice(input_config_choice),
      .twos_complement(twos_complement), .power_mode(power_mode), .power_state(power_state),
      .converting(converting), .ready_to_convert(ready_to_convert), .conv_start(conv_start),
      .sample_strobe(sample_strobe), .sar_ready(sar_ready));
   spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din));

   // -------------------------------------------------------------------
   // clock, start counter, helpers
   // -------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
      if (conv_start === 1'b1)
         starts++;

   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // comparator on, comparator full, reference on
   function automatic logic [2:0] state_of(input logic [1:0] m);
      return (m == 2'h0) ? 3'h0 : (m == 2'h3) ? 3'h7 : 3'h5;
   endfunction

   task automatic check_byte(input logic [7:0] b);
      cmp({5'h00, channel_choice}, {5'h00, b[6:4]}, "channel");
      cmp({7'h00, polarity_choice}, {7'h00, b[3]}, "polarity");
      cmp({7'h00, twos_complement}, {7'h00, ~b[3]}, "coding");
      cmp({7'h00, input_config_choice}, {7'h00, b[2]}, "input");
      cmp({6'h00, power_mode}, {6'h00, b[1:0]}, "mode");
      cmp({5'h00, power_state}, {5'h00, state_of(b[1:0])}, "state");
   endtask

   // bounded wait, then the flag must be up
   task automatic wait_ready(input int limit);
      for (int k = 0; k < limit && ready_to_convert !== 1'b1; k++)
         @(negedge clk);
      cmp({7'h00, ready_to_convert}, 8'h01, "ready");
   endtask

   // -------------------------------------------------------------------
   // tests
   // -------------------------------------------------------------------
   initial
   begin
      arst_n = 1'b0;
      hw_shutdown_n = 1'b1;
      sar_ready = 1'b1;
      repeat (20) @(negedge clk);
      cmp({6'h00, power_mode}, 8'h03, "reset mode");
      cmp({5'h00, power_state}, 8'h07, "reset state");
      arst_n <= 1'b1;
      repeat (395) @(negedge clk);
      cmp({7'h00, ready_to_convert}, 8'h00, "early ready");
      repeat (15) @(negedge clk);
      cmp({7'h00, ready_to_convert}, 8'h01, "wake ready");
      $display("test reset done");
      // every mode code, leading zeros and slow frame ends
      for (int i = 0; i < 4; i++)
      begin
         cmp({7'h00, ready_to_convert}, 8'h01, "no wake wait");
         n0 = starts;
         host.frame(bytes[i], i, 8, 4 * i);
         repeat (10) @(negedge clk);
         cmp(8'(starts - n0), 8'h01, "one start");
         check_byte(bytes[i]);
      end
      host.frame(8'hAB, 0, 8, 0);
      wait_ready(450);
      check_byte(8'hAB);
      $display("test modes done");
      n0 = starts;
      host.frame(8'h93, 0, 4, 0);
      repeat (200) @(negedge clk);
      cmp(8'(starts - n0), 8'h00, "aborted byte");
      check_byte(8'hAB);
      $display("test abort done");
      // core stalls: both bytes must be kept
      sar_ready <= 1'b0;
      host.frame(8'hD7, 0, 8, 0);
      host.frame(8'hEF, 0, 8, 0);
      cmp({5'h00, channel_choice}, 8'h02, "held channel");
      // one pop only: the first kept byte must surface by itself
      sar_ready <= 1'b1;
      @(negedge clk);
      sar_ready <= 1'b0;
      repeat (4) @(negedge clk);
      cmp({5'h00, channel_choice}, 8'h05, "first kept");
      cmp({7'h00, polarity_choice}, 8'h00, "first kept polarity");
      sar_ready <= 1'b1;
      repeat (10) @(negedge clk);
      check_byte(8'hEF);
      $display("test buffer done");
      hw_shutdown_n <= 1'b0;
      repeat (10) @(negedge clk);
      cmp({7'h00, ready_to_convert}, 8'h00, "shutdown ready");
      hw_shutdown_n <= 1'b1;
      repeat (395) @(negedge clk);
      cmp({7'h00, ready_to_convert}, 8'h00, "early wake");
      wait_ready(20);
      $display("test shutdown done");
      results();
   end

   // watchdog well past the expected few thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
